// ==== hdl/tcpc_cfg.svh ====
// Constants for the Type-C port pin control block.
`ifndef TCPC_CFG_SVH
`define TCPC_CFG_SVH
`define TCPC_ADDR_HIGH 7'h67
`define TCPC_ADDR_LOW 7'h47
`define TCPC_STRAP_SETTLE_CYC 16'h0010
`define TCPC_CUR_DEFAULT 2'h0
`define TCPC_CUR_MEDIUM 2'h1
`define TCPC_CUR_HIGH 2'h2
`endif

// ==== hdl/tcpc_pin_ctrl.sv ====
// Pin-level control and status logic of a Type-C configuration channel port.
`include "tcpc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Strap high: I2C enabled at target address 0x67.
// - Strap low: I2C enabled at target address 0x47.
// - Strap open: I2C disabled, shared pins become status outputs.
// - Orientation pin released for plug position 2, pulled low for position 1.
// - I2C mode: interrupt pin pulls low while register contents changed.
// - GPIO mode: interrupt pin pulls low while audio accessory detected.
// - GPIO sink: flag A low for medium or high current.
// - GPIO sink: flag B low only for high current.
// - I2C mode: shared pins carry data and clock; GPIO mode: current flags.
// - Source-attach pin pulled low on attach while acting as source.
// - Sink attach needs bus voltage present.
module tcpc_pin_ctrl (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     strap_high,
  input  wire logic                     strap_low,
  input  wire logic                     enable_n,
  input  wire logic                     bus_voltage_sense,
  input  wire tcpc_pkg::tcpc_cc_status_t cc_status,
  input  wire logic                     reg_changed,
  input  wire logic                     irq_clear,
  input  wire logic                     i2c_sda_oe,
  output logic                          i2c_enable,
  output logic [6:0]                    i2c_target_addr,
  output logic                          device_active,
  output logic                          sink_attached,
  output tcpc_pkg::tcpc_od_t            orient_pin,
  output tcpc_pkg::tcpc_od_t            audio_accessory_flag,
  output tcpc_pkg::tcpc_od_t            current_level_flag_a,
  output tcpc_pkg::tcpc_od_t            current_level_flag_b,
  output tcpc_pkg::tcpc_od_t            source_attach_low
);
  logic [2:0]            sync_q;
  tcpc_pkg::tcpc_strap_t strap_q;
  logic [15:0]           settle_q;
  logic                  strap_done_q;
  logic                  irq_q;
  logic                  act;
  logic                  gpio;
  logic                  vbus_s;

  tcpc_sync #(.W(3)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({strap_high, strap_low, enable_n}),
    .q       (sync_q)
  );

  // The bus-voltage pin comes from outside the clock domain, so it passes two flops like the straps.
  tcpc_sync #(.W(1)) u_sync_vbus (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       (bus_voltage_sense),
    .q       (vbus_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The strap is caught once after reset settles; changing it later needs a reset.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      settle_q     <= 16'h0000;
      strap_done_q <= 1'b0;
      strap_q      <= tcpc_pkg::TCPC_STRAP_OPEN;
    end else if (!strap_done_q) begin
      settle_q <= settle_q + 16'h0001;
      if (settle_q == `TCPC_STRAP_SETTLE_CYC) begin
        strap_done_q <= 1'b1;
        if (sync_q[2])
          strap_q <= tcpc_pkg::TCPC_STRAP_HIGH;
        else if (sync_q[1])
          strap_q <= tcpc_pkg::TCPC_STRAP_LOW;
        else
          strap_q <= tcpc_pkg::TCPC_STRAP_OPEN;
      end
    end
  end

  assign act  = strap_done_q && !sync_q[0];
  assign gpio = strap_q == tcpc_pkg::TCPC_STRAP_OPEN;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      i2c_enable      <= 1'b0;
      i2c_target_addr <= 7'h00;
      device_active   <= 1'b0;
    end else begin
      device_active   <= act;
      i2c_enable      <= act && !gpio;
      i2c_target_addr <= (strap_q == tcpc_pkg::TCPC_STRAP_HIGH) ? `TCPC_ADDR_HIGH : `TCPC_ADDR_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over clear so a change in the clearing cycle is kept.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      irq_q <= 1'b0;
    else if (!act || gpio)
      irq_q <= 1'b0;
    else if (reg_changed)
      irq_q <= 1'b1;
    else if (irq_clear)
      irq_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: o is always zero, oe high pulls the pin low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      orient_pin           <= '0;
      audio_accessory_flag <= '0;
      current_level_flag_a <= '0;
      current_level_flag_b <= '0;
      source_attach_low    <= '0;
      sink_attached        <= 1'b0;
    end else begin
      sink_attached <= act && cc_status.attached && !cc_status.acting_source
                       && vbus_s;
      orient_pin.o <= 1'b0;
      orient_pin.oe <= act && cc_status.attached && !cc_status.flip;
      source_attach_low.o <= 1'b0;
      source_attach_low.oe <= act && cc_status.attached && cc_status.acting_source;
      audio_accessory_flag.o <= 1'b0;
      if (gpio)
        audio_accessory_flag.oe <= act && cc_status.audio;
      else
        audio_accessory_flag.oe <= irq_q;
      current_level_flag_a.o <= 1'b0;
      current_level_flag_b.o <= 1'b0;
      if (gpio) begin
        current_level_flag_a.oe <= act && !cc_status.acting_source && cc_status.attached
                                   && vbus_s
                                   && cc_status.current != `TCPC_CUR_DEFAULT;
        current_level_flag_b.oe <= act && !cc_status.acting_source && cc_status.attached
                                   && vbus_s
                                   && cc_status.current == `TCPC_CUR_HIGH;
      end else begin
        current_level_flag_a.oe <= act && i2c_sda_oe;
        current_level_flag_b.oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_flag_b_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    current_level_flag_b.oe |-> current_level_flag_a.oe
  ) else $error("flag b low without flag a");
  a_flag_b_level: assert property (
    @(posedge clock) disable iff (sys_rst)
    (gpio && cc_status.current != `TCPC_CUR_HIGH) |=> !current_level_flag_b.oe
  ) else $error("flag b low below high current");
  a_flag_a_default: assert property (
    @(posedge clock) disable iff (sys_rst)
    (gpio && cc_status.current == `TCPC_CUR_DEFAULT) |=> !current_level_flag_a.oe
  ) else $error("flag a low at default current");
  a_flag_a_sink: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && gpio && cc_status.attached && !cc_status.acting_source && vbus_s
     && cc_status.current != `TCPC_CUR_DEFAULT) |=> current_level_flag_a.oe
  ) else $error("flag a not low above default current");
  a_i2c_clock_free: assert property (
    @(posedge clock) disable iff (sys_rst)
    !gpio |=> !current_level_flag_b.oe
  ) else $error("clock pin driven in i2c mode");
  a_i2c_data_pin: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && !gpio && i2c_sda_oe) |=> current_level_flag_a.oe
  ) else $error("data pin not driven in i2c mode");
  a_src_attach: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && cc_status.attached && cc_status.acting_source) |=> source_attach_low.oe
  ) else $error("source attach not flagged");
  a_sink_vbus: assert property (
    @(posedge clock) disable iff (sys_rst)
    sink_attached |-> $past(vbus_s)
  ) else $error("sink attach without bus voltage");
  a_orient_pos: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && cc_status.attached && cc_status.flip) |=> !orient_pin.oe
  ) else $error("orientation wrong");
  a_orient_low: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && cc_status.attached && !cc_status.flip) |=> orient_pin.oe
  ) else $error("orientation not pulled low");
  a_addr_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    (i2c_enable && strap_q == tcpc_pkg::TCPC_STRAP_HIGH) |-> i2c_target_addr == 7'h67
  ) else $error("high address wrong");
  a_addr_low: assert property (
    @(posedge clock) disable iff (sys_rst)
    (i2c_enable && strap_q == tcpc_pkg::TCPC_STRAP_LOW) |-> i2c_target_addr == 7'h47
  ) else $error("low address wrong");
  a_gpio_no_i2c: assert property (
    @(posedge clock) disable iff (sys_rst)
    gpio |=> !i2c_enable
  ) else $error("i2c enabled in gpio mode");
  a_strap_locked: assert property (
    @(posedge clock) disable iff (sys_rst)
    strap_done_q |=> $stable(strap_q)
  ) else $error("strap changed after capture");
  a_irq_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && !gpio && reg_changed) |=> ##1 audio_accessory_flag.oe
  ) else $error("interrupt not raised");
  a_irq_set_wins: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && !gpio && reg_changed && irq_clear) |=> irq_q
  ) else $error("clear won over a change");
  a_irq_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && !gpio && irq_q && !irq_clear) |=> irq_q
  ) else $error("interrupt dropped without clear");
  a_audio_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    (act && gpio && cc_status.audio) |=> audio_accessory_flag.oe
  ) else $error("audio flag missing");
  a_disable_quiet: assert property (
    @(posedge clock) disable iff (sys_rst)
    !act |=> !device_active && !i2c_enable && !sink_attached && !orient_pin.oe && !source_attach_low.oe
  ) else $error("active while disabled");
endmodule // tcpc_pin_ctrl
`default_nettype wire

// ==== hdl/tcpc_pkg.sv ====
// Types for the Type-C port pin control block.
package tcpc_pkg;
  typedef enum logic [1:0] {TCPC_STRAP_LOW, TCPC_STRAP_OPEN, TCPC_STRAP_HIGH} tcpc_strap_t;
  typedef enum logic [1:0] {TCPC_ROLE_SINK, TCPC_ROLE_SOURCE, TCPC_ROLE_DUAL} tcpc_role_t;
  typedef struct packed {
    logic       attached;
    logic       acting_source;
    logic       flip;
    logic       audio;
    logic [1:0] current;
  } tcpc_cc_status_t;
  typedef struct packed {
    logic o;
    logic oe;
  } tcpc_od_t;
endpackage

// ==== hdl/tcpc_sync.sv ====
// Two-flop synchroniser, one per bit.
`timescale 1ns/100ps
`default_nettype none
module tcpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1_q <= d[i];
          q[i] <= s1_q;
        end
      end
    end
  endgenerate
endmodule // tcpc_sync
`default_nettype wire

// ==== test/tcpc_pin_ctrl_tb.sv ====
// Self-checking bench for the Type-C port pin control block.
`timescale 1ns/100ps
`default_nettype none
`include "tcpc_cfg.svh"
module tcpc_pin_ctrl_tb;
  logic clock = 1'b0, sys_rst = 1'b1, strap_high = 1'b0, strap_low = 1'b0;
  logic reg_changed = 1'b0, irq_clear = 1'b0, i2c_sda_oe = 1'b0, want_vbus = 1'b0, want_off = 1'b0;
  logic bus_voltage_sense, enable_n, i2c_enable, device_active, sink_attached;
  logic [6:0] i2c_target_addr;
  tcpc_pkg::tcpc_cc_status_t want_cc = '0, cc_status;
  tcpc_pkg::tcpc_od_t orient_pin, audio_accessory_flag, current_level_flag_a, current_level_flag_b, source_attach_low;
  logic [39:0] notes[$];
  int n_errors = 0, check_count = 0;
  event got;
  tcpc_port_model i_tcpc_port_model (.clock(clock), .want_cc(want_cc), .want_vbus(want_vbus),
    .want_off(want_off), .cc_status(cc_status), .bus_voltage_sense(bus_voltage_sense), .enable_n(enable_n));
  tcpc_pin_ctrl i_tcpc_pin_ctrl (.clock(clock), .sys_rst(sys_rst), .strap_high(strap_high),
    .strap_low(strap_low), .enable_n(enable_n), .bus_voltage_sense(bus_voltage_sense), .cc_status(cc_status),
    .reg_changed(reg_changed), .irq_clear(irq_clear), .i2c_sda_oe(i2c_sda_oe), .i2c_enable(i2c_enable),
    .i2c_target_addr(i2c_target_addr), .device_active(device_active), .sink_attached(sink_attached),
    .orient_pin(orient_pin), .audio_accessory_flag(audio_accessory_flag),
    .current_level_flag_a(current_level_flag_a), .current_level_flag_b(current_level_flag_b),
    .source_attach_low(source_attach_low));
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The upper half of a note masks bits the rules leave open, such as the address in status-pin mode.
  task automatic compare(input logic [19:0] act, input logic [39:0] nt);
    check_count++;
    if ((act & nt[39:20]) !== (nt[19:0] & nt[39:20])) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, act & nt[39:20], nt[19:0] & nt[39:20]);
    end
  endtask
  task automatic settle(input logic [6:0] adr, input logic irq);
    logic snk;
    logic gp;
    logic [19:0] m;
    repeat (6) @(negedge clock);
    snk = want_cc.attached & ~want_cc.acting_source & want_vbus;
    gp = (adr == 7'h00);
    m = want_off ? 20'h803FF : {2'h3, {7{~gp}}, 1'b1, want_cc.attached, 9'h1FF};
    notes.push_back({m, want_off ? 20'h00000 : {1'b1, ~gp, adr, snk, ~want_cc.flip,
      gp ? want_cc.audio : irq, gp ? snk & (want_cc.current != 2'h0) : i2c_sda_oe,
      gp & snk & (want_cc.current == 2'h2), want_cc.attached & want_cc.acting_source, 5'h00}});
    -> got;
  endtask
  task automatic run_mode(input logic h, input logic l, input logic [6:0] adr);
    sys_rst = 1'b1;
    strap_high = h;
    strap_low = l;
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    repeat (25) @(negedge clock);
    for (int i = 0; i < 12; i++) begin
      want_cc = 6'($urandom);
      want_cc.current = 2'($urandom_range(2));
      want_vbus = 1'($urandom);
      i2c_sda_oe = 1'($urandom);
      settle(adr, 1'b0);
    end
    want_cc = {1'b1, 1'b0, 1'b1, 1'b1, `TCPC_CUR_HIGH};
    want_vbus = 1'b1;
    settle(adr, 1'b0);
    want_cc = {1'b1, 1'b1, 1'b0, 1'b0, `TCPC_CUR_MEDIUM};
    settle(adr, 1'b0);
    reg_changed = 1'b1;
    @(negedge clock);
    reg_changed = 1'b0;
    settle(adr, adr != 7'h00);
    irq_clear = 1'b1;
    @(negedge clock);
    irq_clear = 1'b0;
    settle(adr, 1'b0);
    reg_changed = 1'b1;
    irq_clear = 1'b1;
    @(negedge clock);
    reg_changed = 1'b0;
    irq_clear = 1'b0;
    settle(adr, adr != 7'h00);
    want_off = 1'b1;
    settle(adr, 1'b0);
    want_off = 1'b0;
    settle(adr, 1'b0);
    $display("test with strap %b%b done", h, l);
  endtask
  always begin
    @(got);
    compare({device_active, i2c_enable, i2c_target_addr, sink_attached, orient_pin.oe, audio_accessory_flag.oe,
      current_level_flag_a.oe, current_level_flag_b.oe, source_attach_low.oe, orient_pin.o,
      audio_accessory_flag.o, current_level_flag_a.o, current_level_flag_b.o,
      source_attach_low.o}, notes.pop_front());
  end
  initial begin
    repeat (50000) @(posedge clock);
    n_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(12));
    run_mode(1'b1, 1'b0, `TCPC_ADDR_HIGH);
    run_mode(1'b0, 1'b1, `TCPC_ADDR_LOW);
    run_mode(1'b0, 1'b0, 7'h00);
    give_verdict;
  end
endmodule // tcpc_pin_ctrl_tb
`default_nettype wire

// ==== test/tcpc_port_model.sv ====
// Behavioural far side: cable state, bus voltage and the system enable.
`timescale 1ns/100ps
`default_nettype none
module tcpc_port_model (
  input  wire logic                      clock,
  input  wire tcpc_pkg::tcpc_cc_status_t want_cc,
  input  wire logic                      want_vbus,
  input  wire logic                      want_off,
  output tcpc_pkg::tcpc_cc_status_t      cc_status,
  output logic                           bus_voltage_sense,
  output logic                           enable_n
);
  initial begin
    cc_status = '0;
    bus_voltage_sense = 1'b0;
    enable_n = 1'b0;
  end
  // Changes land on the falling edge so the block never samples a level mid-change.
  always @(negedge clock) begin
    cc_status <= want_cc;
    bus_voltage_sense <= want_vbus;
    enable_n <= want_off;
  end
endmodule // tcpc_port_model
`default_nettype wire
